// ==== rtl/ilo_consts.svh ====
// Constants for the indexed literal offset address unit
`ifndef ILO_CONSTS_SVH
`define ILO_CONSTS_SVH
// Register byte addresses
`define ILO_CTRL_ADDR 12'h000
`define ILO_SFP_ADDR 12'h004
`define ILO_INSTR_ADDR 12'h008
`define ILO_RESULT_ADDR 12'h00c
// Control register fields
`define ILO_CTRL_EXT_BIT 0
`define ILO_CTRL_BANK_LSB 8
// Instruction register fields
`define ILO_INSTR_A_BIT 8
`define ILO_INSTR_D_BIT 9
// Result register fields
`define ILO_RES_ADDR_LSB 0
`define ILO_RES_IDX_BIT 16
`define ILO_RES_ACC_BIT 17
`define ILO_RES_EXT_BIT 18
// Offset limit and access bank split
`define ILO_OFFSET_MAX 8'h5f
`define ILO_ACCESS_LOW_MAX 8'h5f
// Reset values and special register bank
`define ILO_CTRL_RST 32'h0000_0000
`define ILO_EXT_RST 1'b0
`define ILO_SFP_RST 12'h000
`define ILO_INSTR_RST 10'h200
`define ILO_SFR_BANK 4'hf
`endif

// ==== rtl/ilo_pkg.sv ====
// Types for the indexed literal offset address unit
package ilo_pkg;
  typedef enum logic [1:0] {
    MODE_ACCESS = 2'b00,
    MODE_BANKED = 2'b01,
    MODE_INDEXED = 2'b11
  } addr_mode_t;
endpackage

// ==== rtl/ilo_addr_unit.sv ====
// Effective data address unit for file-operand instructions, AHB-Lite
`timescale 1ns/1ps
`include "ilo_consts.svh"

module ilo_addr_unit
  import ilo_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk_i,              // Core clock, 125 MHz
  input wire logic resetn_i,           // Synchronous reset, active low
  input wire logic ce_i,               // Clock enable, freezes all state except synchronous reset
  input wire logic hsel_i,             // AHB-Lite select
  input wire logic [31:0] haddr_i,     // AHB-Lite address
  input wire logic [1:0] htrans_i,     // AHB-Lite transfer type
  input wire logic hwrite_i,           // AHB-Lite write
  input wire logic [2:0] hsize_i,      // AHB-Lite size
  input wire logic [31:0] hwdata_i,    // AHB-Lite write data
  input wire logic hready_i,           // AHB-Lite bus ready
  output logic [31:0] hrdata_o,        // AHB-Lite read data
  output logic hreadyout_o,            // AHB-Lite slave ready
  output logic hresp_o,                // AHB-Lite response, always OKAY
  output logic ext_en_o,               // Extended instruction set enabled
  output logic [ADDR_W-1:0] eff_addr_o, // Effective data address
  output logic dest_acc_o,             // Result goes to accumulator
  output logic indexed_o               // Current operand is indexed
);

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic ext_en;
    logic [3:0] bank;
    logic [ADDR_W-1:0] sfp;
    logic [9:0] instr;
    logic [ADDR_W-1:0] eff_addr;
    logic dest_acc;
    addr_mode_t mode;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Address for one file operand; shared by decode and readback
  function automatic logic [ADDR_W-1:0] calc_addr(
    input logic ext, input logic a, input logic [7:0] f,
    input logic [3:0] bnk, input logic [ADDR_W-1:0] ptr);
    logic [ADDR_W-1:0] r;
    r = '0;
    if (ext && !a && f <= `ILO_OFFSET_MAX) begin
      // Wraps within the data space; pointer 0 gives plain offsets
      r = ptr + {{(ADDR_W-8){1'b0}}, f};
    end else if (a) begin
      r = {bnk, f};
    end else if (f <= `ILO_ACCESS_LOW_MAX) begin
      r = {4'h0, f};
    end else begin
      // Access Bank offsets above 0x5f map onto the special register bank
      r = {`ILO_SFR_BANK, f};
    end
    return r;
  endfunction

  function automatic addr_mode_t calc_mode(
    input logic ext, input logic a, input logic [7:0] f);
    addr_mode_t m;
    m = MODE_ACCESS;
    if (ext && !a && f <= `ILO_OFFSET_MAX) begin
      m = MODE_INDEXED;
    end else if (a) begin
      m = MODE_BANKED;
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic addr_ok;
  logic [11:0] a_cur;
  assign addr_ok = hsel_i && hready_i && htrans_i[1];
  assign a_cur = haddr_i[11:0];

  always_comb begin
    st_nxt = st_r;
    st_nxt.wr_pend = 1'b0;
    // Deferred write from the previous address phase
    if (st_r.wr_pend) begin
      unique case (st_r.wr_addr)
        `ILO_CTRL_ADDR: begin
          st_nxt.ext_en = hwdata_i[`ILO_CTRL_EXT_BIT];
          st_nxt.bank = hwdata_i[`ILO_CTRL_BANK_LSB +: 4];
        end
        `ILO_SFP_ADDR: st_nxt.sfp = hwdata_i[ADDR_W-1:0];
        `ILO_INSTR_ADDR: st_nxt.instr = hwdata_i[9:0];
        default: ;
      endcase
    end
    // Decode uses the next state including this cycle's deferred write, so every operand sees one rule
    st_nxt.mode = calc_mode(st_nxt.ext_en, st_nxt.instr[`ILO_INSTR_A_BIT],
                            st_nxt.instr[7:0]);
    st_nxt.eff_addr = calc_addr(st_nxt.ext_en,
                                st_nxt.instr[`ILO_INSTR_A_BIT],
                                st_nxt.instr[7:0], st_nxt.bank,
                                st_nxt.sfp);
    // Destination bit is independent of the addressing mode
    st_nxt.dest_acc = !st_nxt.instr[`ILO_INSTR_D_BIT];
    if (addr_ok) begin
      st_nxt.wr_pend = hwrite_i;
      st_nxt.wr_addr = a_cur;
      st_nxt.rdata = 32'h0000_0000;
      if (!hwrite_i) begin
        unique case (a_cur)
          `ILO_CTRL_ADDR: begin
            st_nxt.rdata[`ILO_CTRL_EXT_BIT] = st_nxt.ext_en;
            st_nxt.rdata[`ILO_CTRL_BANK_LSB +: 4] = st_nxt.bank;
          end
          `ILO_SFP_ADDR: st_nxt.rdata[ADDR_W-1:0] = st_nxt.sfp;
          `ILO_INSTR_ADDR: st_nxt.rdata[9:0] = st_nxt.instr;
          `ILO_RESULT_ADDR: begin
            st_nxt.rdata[`ILO_RES_ADDR_LSB +: ADDR_W] = st_nxt.eff_addr;
            st_nxt.rdata[`ILO_RES_IDX_BIT] = (st_nxt.mode == MODE_INDEXED);
            st_nxt.rdata[`ILO_RES_ACC_BIT] = st_nxt.dest_acc;
            st_nxt.rdata[`ILO_RES_EXT_BIT] = st_nxt.ext_en;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_r <= '0;
      st_r.ext_en <= `ILO_EXT_RST;
      st_r.sfp <= `ILO_SFP_RST;
      st_r.instr <= `ILO_INSTR_RST;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign hrdata_o = st_r.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign ext_en_o = st_r.ext_en;
  assign eff_addr_o = st_r.eff_addr;
  assign dest_acc_o = st_r.dest_acc;
  // Only the indexed code has its upper bit set, so this is a bare flop
  assign indexed_o = st_r.mode[1];

endmodule

// ==== tb/ilo_addr_unit_asserts.sv ====
// Checker for the effective address unit ports
`timescale 1ns/1ps
module ilo_addr_unit_chk #(parameter int ADDR_W = 12) (
  input wire logic clk_i, resetn_i, ce_i, hsel_i, hwrite_i, hready_i,
  input wire logic [1:0] htrans_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o, hresp_o, ext_en_o, dest_acc_o, indexed_o,
  input wire logic [ADDR_W-1:0] eff_addr_o
);
  logic tk;
  logic wr;
  assign tk = ce_i && hsel_i && hready_i && htrans_i[1];
  assign wr = tk && hwrite_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_ready_always: assert property (hreadyout_o) else $error("wait state");
  chk_resp_okay: assert property (!hresp_o) else $error("bad response");
  chk_idx_needs_ext: assert property (indexed_o |-> ext_en_o)
    else $error("indexed without extension");
  chk_ext_by_write: assert property ($changed(ext_en_o) && $past(resetn_i) |-> $past(wr, 2))
    else $error("enable moved without write");
  chk_addr_by_write: assert property ($changed(eff_addr_o) && $past(resetn_i) |-> $past(wr, 2))
    else $error("address moved without write");
  chk_dest_by_write: assert property ($changed(dest_acc_o) && $past(resetn_i) |-> $past(wr, 2))
    else $error("destination moved without write");
  chk_rdata_by_xfer: assert property ($changed(hrdata_o) && $past(resetn_i) |-> $past(tk))
    else $error("read data moved without transfer");
  chk_freeze_hold: assert property (!ce_i |=> $stable(eff_addr_o))
    else $error("state moved while frozen");
endmodule
bind ilo_addr_unit ilo_addr_unit_chk #(.ADDR_W(ADDR_W)) chk (.clk_i, .resetn_i,
  .ce_i, .hsel_i, .hwrite_i, .hready_i, .htrans_i, .hrdata_o, .hreadyout_o,
  .hresp_o, .ext_en_o, .dest_acc_o, .indexed_o, .eff_addr_o);

// ==== tb/ilo_addr_unit_tb.sv ====
// Self-checking bench for the effective address unit
`timescale 1ns/1ps
`include "ilo_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module ilo_addr_unit_tb;
  logic clk_i = 0, resetn_i = 0, ce_i = 1, hsel_i = 0, hwrite_i = 0;
  logic [1:0] htrans_i = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, r;
  logic hreadyout_o, hresp_o, ext_en_o, dest_acc_o, indexed_o;
  logic [11:0] eff_addr_o;
  int fails = 0, checks = 0;
  ilo_addr_unit dut (.clk_i, .resetn_i, .ce_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(3'b010), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
    .hreadyout_o, .hresp_o, .ext_en_o, .eff_addr_o, .dest_acc_o, .indexed_o);
  initial forever #4 clk_i = ~clk_i;
  task test_done;
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wait_rdy;
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 20);
    if (n >= 20) begin fails++; test_done; end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel_i <= 1; htrans_i <= 2'b10; hwrite_i <= w; haddr_i <= {20'h0, a};
    wait_rdy;
    hsel_i <= 0; htrans_i <= 2'b00; hwdata_i <= d;
    wait_rdy;
    r = hrdata_o;
  endtask
  task cfg(input logic [31:0] c, s, i, res);
    bus(1, `ILO_CTRL_ADDR, c); bus(1, `ILO_SFP_ADDR, s);
    bus(1, `ILO_INSTR_ADDR, i); bus(0, `ILO_RESULT_ADDR, 0);
    `CHK(r, res)
  endtask
  task t_reset;
    resetn_i <= 0; @(posedge clk_i); resetn_i <= 1;
    bus(0, `ILO_RESULT_ADDR, 0); `CHK(r, 32'h0)
  endtask
  task t_literal;
    cfg(32'h300, 32'h0, 32'h340, 32'h0000_0340);
    cfg(32'h300, 32'h0, 32'h240, 32'h0000_0040);
    cfg(32'h300, 32'h10, 32'h280, 32'h0000_0f80);
    `CHK(ext_en_o, 1'b0)
  endtask
  task t_indexed;
    cfg(32'h1, 32'hffa, 32'h010, 32'h0007_000a);
    `CHK(ext_en_o, 1'b1)
    `CHK({indexed_o, dest_acc_o, eff_addr_o}, 14'h300a)
    cfg(32'h1, 32'h100, 32'h25f, 32'h0005_015f);
    cfg(32'h1, 32'h100, 32'h260, 32'h0004_0f60);
    cfg(32'h201, 32'h100, 32'h320, 32'h0004_0220);
  endtask
  task t_zero_ptr;
    cfg(32'h1, 32'h0, 32'h220, 32'h0005_0020);
    ce_i <= 0; bus(1, `ILO_SFP_ADDR, 32'h55); ce_i <= 1;
    `CHK(eff_addr_o, 12'h020)
    bus(1, 12'h010, 32'hffff_ffff); bus(0, 12'h010, 0); `CHK(r, 32'h0)
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1;
    t_literal; t_indexed; t_zero_ptr; t_reset;
    test_done;
  end
endmodule
